/* rtl/rml_defines.svh */
// Constants for the reset mode latch: strap codes, ratio encodings and sync depth.
// Assumes inclusion by bare name from the design files.
`ifndef RML_DEFINES_SVH
`define RML_DEFINES_SVH
`define RML_STRAP_W 5
`define RML_STRAP_LSB 8
`define RML_STRAP_MSB 12
`define RML_CODE_HI 5'h03
`define RML_CODE_LO 5'h05
`define RML_CODE_X4 5'h0F
`define RML_RATIO_W 3
`define RML_RATIO_NONE 3'h0
`define RML_RATIO_X2 3'h2
`define RML_RATIO_X4 3'h4
`define RML_MIN_RESET_CYCLES 5
`define RML_SYNC_STAGES 2
`endif

/* rtl/rml_pkg.sv */
// Types shared by the reset mode latch.
// Assumes the defines header is compiled alongside.
`include "rml_defines.svh"
package rml_pkg;
    typedef enum logic [1:0] {
        RML_BAND_NONE,
        RML_BAND_HIGH,
        RML_BAND_LOW,
        RML_BAND_QUAD
    } rml_band_type;
endpackage : rml_pkg

/* rtl/rml_sync.sv */
// Two-flop synchroniser for a bus of levels.
// Assumes every input bit is a level that may change at any time.
`timescale 1ns/1ps
`include "rml_defines.svh"
module rml_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    if (WIDTH < 1) begin : g_width_check
        $error("rml_sync needs WIDTH of at least one");
    end

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule : rml_sync

/* rtl/rml_reset_mode_latch.sv */
// Reset qualification and power-up clock-ratio capture.
// Assumes mclk is the reference clock; reset_n is the local power-on reset.
`timescale 1ns/1ps
`include "rml_defines.svh"
module rml_reset_mode_latch #(
    parameter int MIN_RESET_CYCLES = `RML_MIN_RESET_CYCLES
) (
    // Clock and local reset
    input wire logic mclk,
    input wire logic reset_n,
    // Board reset and straps
    input wire logic reset_in_n,
    input wire logic [`RML_STRAP_MSB:`RML_STRAP_LSB] strap_ad,
    // Results
    output logic reset_out_n,
    output logic [`RML_STRAP_W-1:0] strap_code,
    output logic [`RML_RATIO_W-1:0] bus_ratio,
    output rml_pkg::rml_band_type ratio_band,
    output logic strap_reserved,
    output logic mode_valid
);
    localparam int CW = $clog2(MIN_RESET_CYCLES + 1);

    // Elaboration stops here rather than building a latch that can never arm.
    if (MIN_RESET_CYCLES < 1) begin : g_min_check
        $error("MIN_RESET_CYCLES must be at least one");
    end

    logic rst_sync;
    logic [`RML_STRAP_W-1:0] strap_sync;

    rml_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(reset_in_n),
        .sync_out(rst_sync)
    );

    rml_sync #(.WIDTH(`RML_STRAP_W), .INIT('0)) u_strap_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(strap_ad),
        .sync_out(strap_sync)
    );

    logic rst_seen_reg;
    logic rst_seen_next;
    logic [CW-1:0] low_cnt_reg;
    logic [CW-1:0] low_cnt_next;
    logic armed_reg;
    logic armed_next;
    logic [`RML_STRAP_W-1:0] strap_prev_reg;
    logic [`RML_STRAP_W-1:0] strap_prev_next;
    // Capture state, held until the next accepted board reset.
    logic [`RML_STRAP_W-1:0] code_reg;
    logic [`RML_STRAP_W-1:0] code_next;
    logic [`RML_RATIO_W-1:0] ratio_reg;
    logic [`RML_RATIO_W-1:0] ratio_next;
    rml_pkg::rml_band_type band_reg;
    rml_pkg::rml_band_type band_next;
    logic rsvd_reg;
    logic rsvd_next;
    logic valid_reg;
    logic valid_next;
    logic rout_reg;
    logic rout_next;
    logic release_seen;

    // Release is the first cycle the synchronised input reads high after a qualified low.
    assign release_seen = rst_sync && !rst_seen_reg && armed_reg;

    always_comb begin
        rst_seen_next = rst_sync;
        low_cnt_next = low_cnt_reg;
        armed_next = armed_reg;
        strap_prev_next = strap_sync;
        code_next = code_reg;
        ratio_next = ratio_reg;
        band_next = band_reg;
        rsvd_next = rsvd_reg;
        valid_next = valid_reg;
        rout_next = rout_reg;
        if (!rst_sync) begin
            // Short glitches never arm a capture, so noise cannot alter the ratio.
            if (low_cnt_reg < CW'(MIN_RESET_CYCLES)) begin
                low_cnt_next = low_cnt_reg + CW'(1);
            end
            if (low_cnt_reg >= CW'(MIN_RESET_CYCLES - 1)) begin
                armed_next = 1'b1;
                valid_next = 1'b0;
                rout_next = 1'b0;
            end
        end else begin
            low_cnt_next = '0;
            if (release_seen) begin
                armed_next = 1'b0;
                code_next = strap_prev_reg;
                valid_next = 1'b1;
                rout_next = 1'b1;
                rsvd_next = 1'b0;
                unique case (strap_prev_reg)
                    `RML_CODE_HI: begin
                        ratio_next = `RML_RATIO_X2;
                        band_next = rml_pkg::RML_BAND_HIGH;
                    end
                    `RML_CODE_LO: begin
                        ratio_next = `RML_RATIO_X2;
                        band_next = rml_pkg::RML_BAND_LOW;
                    end
                    `RML_CODE_X4: begin
                        ratio_next = `RML_RATIO_X4;
                        band_next = rml_pkg::RML_BAND_QUAD;
                    end
                    default: begin
                        // Reserved strap: flag it and leave no ratio selected.
                        ratio_next = `RML_RATIO_NONE;
                        band_next = rml_pkg::RML_BAND_NONE;
                        rsvd_next = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rst_seen_reg <= 1'b0;
            low_cnt_reg <= '0;
            armed_reg <= 1'b0;
            strap_prev_reg <= '0;
            code_reg <= '0;
            ratio_reg <= `RML_RATIO_NONE;
            band_reg <= rml_pkg::RML_BAND_NONE;
            rsvd_reg <= 1'b0;
            valid_reg <= 1'b0;
            rout_reg <= 1'b0;
        end else begin
            rst_seen_reg <= rst_seen_next;
            low_cnt_reg <= low_cnt_next;
            armed_reg <= armed_next;
            strap_prev_reg <= strap_prev_next;
            code_reg <= code_next;
            ratio_reg <= ratio_next;
            band_reg <= band_next;
            rsvd_reg <= rsvd_next;
            valid_reg <= valid_next;
            rout_reg <= rout_next;
        end
    end

    assign reset_out_n = rout_reg;
    assign strap_code = code_reg;
    assign bus_ratio = ratio_reg;
    assign ratio_band = band_reg;
    assign strap_reserved = rsvd_reg;
    assign mode_valid = valid_reg;

    // Independent count of consecutive synchronised low cycles, read only by the assertions below.
    logic [CW-1:0] low_run_reg;
    logic [CW-1:0] low_run_next;

    always_comb begin
        low_run_next = low_run_reg;
        if (rst_sync) begin
            low_run_next = '0;
        end else if (low_run_reg < CW'(MIN_RESET_CYCLES)) begin
            low_run_next = low_run_reg + CW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            low_run_reg <= '0;
        end else begin
            low_run_reg <= low_run_next;
        end
    end

    // Assertions.
    a_ratio_x4_decode: assert property (@(posedge mclk) disable iff (!reset_n)
        (release_seen && strap_prev_reg == `RML_CODE_X4) |=> (bus_ratio == `RML_RATIO_X4))
        else $error("strap 01111 did not give ratio 1:4");
    a_ratio_x2_decode: assert property (@(posedge mclk) disable iff (!reset_n)
        (release_seen && (strap_prev_reg == `RML_CODE_HI || strap_prev_reg == `RML_CODE_LO))
        |=> (bus_ratio == `RML_RATIO_X2))
        else $error("strap 00011 or 00101 did not give ratio 1:2");
    a_reserved_flag: assert property (@(posedge mclk) disable iff (!reset_n)
        mode_valid |-> (strap_reserved == (bus_ratio == `RML_RATIO_NONE)))
        else $error("reserved flag disagrees with ratio");
    a_short_pulse_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
        ($fell(mode_valid) || $fell(reset_out_n))
        |-> (!$past(rst_sync) && $past(low_run_reg) >= CW'(MIN_RESET_CYCLES - 1)))
        else $error("reset output dropped after a low pulse shorter than the minimum");
    // The synchroniser holds its reset value for two edges after local reset, so those edges are skipped.
    a_sync_latency: assert property (@(posedge mclk) disable iff (!reset_n)
        ($past(reset_n) && $past(reset_n, `RML_SYNC_STAGES))
        |-> ($past(reset_in_n, `RML_SYNC_STAGES) == rst_sync))
        else $error("reset synchroniser latency is not two cycles");
    a_capture_prev_edge: assert property (@(posedge mclk) disable iff (!reset_n)
        release_seen |=> (strap_code == $past(strap_sync, 2)))
        else $error("strap not taken from edge before release");
    a_code_held: assert property (@(posedge mclk) disable iff (!reset_n)
        (mode_valid && $past(mode_valid) && !release_seen && !$past(release_seen)) |-> $stable(strap_code))
        else $error("captured code changed during operation");
    a_release_out: assert property (@(posedge mclk) disable iff (!reset_n)
        release_seen |=> (reset_out_n && mode_valid) ##1 reset_out_n)
        else $error("reset output did not release after recognition");
    a_long_low_accepted: assert property (@(posedge mclk) disable iff (!reset_n)
        (!rst_sync && low_run_reg >= CW'(MIN_RESET_CYCLES - 1)) |=> (!mode_valid && !reset_out_n))
        else $error("minimum-length board reset was not accepted");
    a_ratio_held: assert property (@(posedge mclk) disable iff (!reset_n)
        (mode_valid && $past(mode_valid)) |-> ($stable(bus_ratio) && $stable(ratio_band)))
        else $error("clock ratio changed during operation");
    c_quad: cover property (@(posedge mclk) disable iff (!reset_n) release_seen && strap_prev_reg == `RML_CODE_X4);
    c_high: cover property (@(posedge mclk) disable iff (!reset_n) release_seen && strap_prev_reg == `RML_CODE_HI);
    c_reserved: cover property (@(posedge mclk) disable iff (!reset_n) release_seen && strap_reserved == 1'b0 ##1 strap_reserved);
    c_second_reset: cover property (@(posedge mclk) disable iff (!reset_n) mode_valid ##1 !mode_valid);
    c_refused_pulse: cover property (@(posedge mclk) disable iff (!reset_n)
        mode_valid && $rose(rst_sync) && low_run_reg == CW'(MIN_RESET_CYCLES - 1));
endmodule : rml_reset_mode_latch

/* verification/rml_board_model.sv */
// Board-side model: the reset source and the ratio strap resistors.
// Assumes the bench calls its task from one process, clocked by the reference clock.
`timescale 1ns/1ps
module rml_board_model (
    // Clock
    input wire logic mclk,
    // Board pins
    output logic reset_in_n,
    output logic [4:0] strap_ad
);
    initial begin
        reset_in_n = 1'b1;
        strap_ad = 5'h00;
    end

    // Straps are only held around the release; afterwards the pins show the inverse, as nothing holds them.
    task automatic board_reset(input int low_cycles, input logic [4:0] code);
        @(posedge mclk);
        reset_in_n <= 1'b0;
        strap_ad <= code;
        repeat (low_cycles) @(posedge mclk);
        reset_in_n <= 1'b1;
        repeat (4) @(posedge mclk);
        strap_ad <= ~code;
    endtask : board_reset
endmodule : rml_board_model

/* verification/tb_reset_mode_latch.sv */
// Self-checking bench for the reset mode latch.
// Assumes the board model drives the board pins and the bench owns clock and local reset.
`timescale 1ns/1ps
module tb_reset_mode_latch;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic reset_in_n;
    logic [4:0] strap_ad;
    logic reset_out_n;
    logic [4:0] strap_code;
    logic [2:0] bus_ratio;
    rml_pkg::rml_band_type ratio_band;
    logic strap_reserved;
    logic mode_valid;
    int n_errors = 0;
    int samples_checked = 0;

    always #5 mclk = ~mclk;

    rml_board_model i_board (
        .mclk(mclk),
        .reset_in_n(reset_in_n),
        .strap_ad(strap_ad)
    );

    rml_reset_mode_latch #(.MIN_RESET_CYCLES(5)) i_dut (
        .mclk(mclk),
        .reset_n(reset_n),
        .reset_in_n(reset_in_n),
        .strap_ad(strap_ad),
        .reset_out_n(reset_out_n),
        .strap_code(strap_code),
        .bus_ratio(bus_ratio),
        .ratio_band(ratio_band),
        .strap_reserved(strap_reserved),
        .mode_valid(mode_valid)
    );

    task automatic complete_run();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    // Checks every result port against the expected captured mode.
    task automatic check_mode(input logic [4:0] code, input logic [2:0] ratio, input logic [1:0] band,
                              input logic rsvd);
        check_val({7'h00, reset_out_n}, 8'h01);
        check_val({3'h0, strap_code}, {3'h0, code});
        check_val({5'h00, bus_ratio}, {5'h00, ratio});
        check_val({6'h00, ratio_band}, {6'h00, band});
        check_val({7'h00, strap_reserved}, {7'h00, rsvd});
        check_val({7'h00, mode_valid}, 8'h01);
    endtask : check_mode

    // A board reset of exactly the minimum length; reset_out_n and mode_valid must drop, then the outputs show the captured mode.
    task automatic run_code(input logic [4:0] code, input logic [2:0] ratio, input logic [1:0] band,
                            input logic rsvd);
        fork
            i_board.board_reset(5, code);
            begin
                repeat (8) @(posedge mclk);
                #1;
                check_val({7'h00, reset_out_n}, 8'h00);
                check_val({7'h00, mode_valid}, 8'h00);
            end
        join
        repeat (2) @(posedge mclk);
        #1;
        check_mode(code, ratio, band, rsvd);
    endtask : run_code

    // A pulse one cycle short must leave the mode untouched even though the straps now differ.
    task automatic run_short_pulse();
        i_board.board_reset(4, 5'h03);
        repeat (4) @(posedge mclk);
        #1;
        check_mode(5'h0F, 3'h4, 2'h3, 1'b0);
    endtask : run_short_pulse

    initial begin
        #100us;
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
        check_val({7'h00, mode_valid}, 8'h00);
        run_code(5'h03, 3'h2, 2'h1, 1'b0);
        run_code(5'h05, 3'h2, 2'h2, 1'b0);
        run_code(5'h00, 3'h0, 2'h0, 1'b1);
        run_code(5'h0F, 3'h4, 2'h3, 1'b0);
        run_short_pulse();
        complete_run();
    end
endmodule : tb_reset_mode_latch
